// [src/apc_pkg.sv]
// package for the absolute position and positioning-done parameter block
package apc_pkg;

   // register word byte addresses
   localparam logic [7:0] ADR_LIN_OFS_LO   = 8'h00;
   localparam logic [7:0] ADR_LIN_OFS_HI   = 8'h04;
   localparam logic [7:0] ADR_GEAR_NUM     = 8'h08;
   localparam logic [7:0] ADR_GEAR_DEN     = 8'h0C;
   localparam logic [7:0] ADR_REV_PUL_LO   = 8'h10;
   localparam logic [7:0] ADR_REV_PUL_HI   = 8'h14;
   localparam logic [7:0] ADR_HS_SPEED     = 8'h18;
   localparam logic [7:0] ADR_HS_TORQUE    = 8'h1C;
   localparam logic [7:0] ADR_DWELL        = 8'h20;
   localparam logic [7:0] ADR_HOLD         = 8'h24;
   localparam logic [7:0] ADR_DIV_WIDE     = 8'h28;
   localparam logic [7:0] ADR_CTRL         = 8'h2C;
   localparam logic [7:0] ADR_LEGACY_DIV   = 8'h30;
   localparam logic [7:0] ADR_STATUS       = 8'h34;
   localparam logic [7:0] ADR_IRQ_STAT     = 8'h38;
   localparam logic [7:0] ADR_IRQ_MASK     = 8'h3C;
   localparam logic [7:0] ADR_ACT_OFS_LO   = 8'h40;
   localparam logic [7:0] ADR_ACT_OFS_HI   = 8'h44;

   // reset values
   localparam logic [15:0] RST_GEAR_NUM   = 16'hFFFF;
   localparam logic [15:0] RST_GEAR_DEN   = 16'h0001;
   localparam logic [15:0] RST_HS_SPEED   = 16'h0002;
   localparam logic [15:0] RST_HS_TORQUE  = 16'h03E8;   // 100.0 percent in 0.1 steps
   localparam logic [15:0] RST_DWELL      = 16'h0000;
   localparam logic [15:0] RST_HOLD       = 16'h0001;
   localparam logic [1:0]  RST_COND       = 2'h0;
   localparam logic        RST_POL        = 1'b1;
   localparam logic [1:0]  RST_ABS_MODE   = 2'h0;

   // limits
   localparam logic [15:0] GEAR_MIN       = 16'h0001;
   localparam logic [6:0]  REV_HI_MAX     = 7'h7F;
   localparam logic [15:0] HS_SPEED_MAX   = 16'h03E8;   // 1000 rpm
   localparam logic [15:0] HS_TORQUE_MAX  = 16'h0BB8;   // 300.0 percent
   localparam logic [15:0] TIME_MIN       = 16'h0001;
   localparam logic [15:0] TIME_MAX       = 16'h7530;   // 30000 ms
   localparam logic [31:0] DIV_MAX        = 32'h0003FFFF;
   localparam logic [31:0] DIV_WIDE_MIN   = 32'h00000023;   // 35

   // modes
   localparam logic [1:0]  ABS_LINEAR     = 2'h1;
   localparam logic [1:0]  ABS_ROTATING   = 2'h2;
   localparam logic [1:0]  COND_HOLD      = 2'h3;

   // control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_COND_LSB = 2;
   localparam int CTRL_POL_BIT  = 4;

   // irq bits
   localparam int IRQ_DONE_RISE = 0;
   localparam int IRQ_DONE_DROP = 1;
   localparam int IRQ_HIT_STOP  = 2;
   localparam int IRQ_W         = 3;

   // timing
   localparam int CLK_HZ         = 25000000;
   localparam int MS_PER_S       = 1000;
   localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
   localparam logic [14:0] CYC_PER_MS_M1 = 15'(CYC_PER_MS - 1);

   // parameters that take effect from the next power-up
   typedef struct packed {
      logic [1:0]  abs_mode;
      logic        pol;
      logic [31:0] ofs_lo;
      logic [31:0] ofs_hi;
      logic [15:0] gear_num;
      logic [15:0] gear_den;
      logic [31:0] rev_lo;
      logic [6:0]  rev_hi;
      logic [31:0] div_wide;
   } apc_boot_t;

   // all state of the block
   typedef struct packed {
      apc_boot_t   pend;
      apc_boot_t   act;
      logic        booted;
      logic [1:0]  cond;
      logic [15:0] hs_speed;
      logic [15:0] hs_torque;
      logic [15:0] dwell;
      logic [15:0] hold;
      logic [31:0] legacy_div;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [14:0] ms_pre;
      logic [15:0] dwell_cnt;
      logic [15:0] hold_cnt;
      logic        done;
      logic        hit;
      logic        ack;
      logic [31:0] rdata;
      logic        done_pin;
      logic [15:0] trq_lim;
      logic [31:0] div_used;
   } apc_state_t;

endpackage : apc_pkg

// [src/apc_top.sv]
// absolute position, hit-and-stop and positioning-done parameter block
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - linear mode: offset equals encoder absolute minus mechanical position.
// - offset kept as signed low and high 32-bit words, default zero.
// - rotating mode gear numerator and denominator limited 1..65535, defaults 65535, 1.
// - load pulses: 32-bit low word, high part limited 0..127.
// - hit-and-stop end judged when speed below threshold 0..1000 rpm, default 2.
// - hit-and-stop clamps both torque directions to 0..300.0 percent, default 100.0.
// - done asserted only after deviation stays in band longer than dwell time.
// - condition 3: done held valid for holding time 1..30000 ms.
// - within holding time, done drops at once on nonzero position reference.
// - division count is legacy value below 35, else the wide value.
// - done pin high when polarity is 0, low when polarity is 1.
module apc_top (
   input  wire logic        CORE_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CLK_EN,
   input  wire logic        POWER_UP,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        HIT_STOP_ACTIVE,
   input  wire logic [15:0] MOTOR_SPEED_RPM,
   input  wire logic        DEV_IN_BAND,
   input  wire logic        POS_REF_NONZERO,
   output logic             POS_DONE_OUT,
   output logic             HIT_END_REACHED,
   output logic      [15:0] TORQUE_LIMIT,
   output logic      [31:0] DIVISION_COUNT,
   output logic      [1:0]  ABS_MODE,
   output logic      [63:0] POS_OFFSET,
   output logic      [15:0] GEAR_NUM,
   output logic      [15:0] GEAR_DEN,
   output logic      [38:0] REV_PULSES,
   output logic             IRQ
);

   apc_pkg::apc_state_t s_reg;
   apc_pkg::apc_state_t s_next;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0]  sel
   );
      logic [31:0] r;
      // lanes with select low keep the stored byte
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // clamp a 16-bit value into [lo, hi]
   function automatic logic [15:0] clamp16(
      input logic [15:0] v,
      input logic [15:0] lo,
      input logic [15:0] hi
   );
      // lower bound first, so with lo above hi, v below lo yields lo and any other v yields hi
      if (v < lo) begin
         return lo;
      end
      if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   // request qualifiers
   logic        wr;
   logic        rd_cyc;
   // merged write word, scratch only
   logic [31:0] wdat;
   // single-cycle event strobes
   logic        done_rise;
   logic        done_drop;
   logic        hit_rise;
   // one pulse per millisecond
   logic        tick;

   // a held request is taken once: never while ack is out
   assign wr     = WB_CYC_I && WB_STB_I && WB_WE_I && !s_reg.ack;
   assign rd_cyc = WB_CYC_I && WB_STB_I && !s_reg.ack;

   // next-state logic
   always_comb begin
      s_next = s_reg;
      // scratch and strobes low unless set below
      wdat   = 32'h0;
      done_rise = 1'b0;
      done_drop = 1'b0;
      hit_rise  = 1'b0;
      tick      = 1'b0;

      // bus slave: one wait state, ack dropped the cycle after
      s_next.ack = rd_cyc;
      if (wr) begin
         case (WB_ADR_I)
            // offset halves: signed words, power-on set
            apc_pkg::ADR_LIN_OFS_LO: begin
               s_next.pend.ofs_lo = merge(s_reg.pend.ofs_lo, WB_DAT_I, WB_SEL_I);
            end

            apc_pkg::ADR_LIN_OFS_HI: begin
               s_next.pend.ofs_hi = merge(s_reg.pend.ofs_hi, WB_DAT_I, WB_SEL_I);
            end

            // gear terms: zero is raised to one
            apc_pkg::ADR_GEAR_NUM: begin
               wdat = merge({16'h0, s_reg.pend.gear_num}, WB_DAT_I, WB_SEL_I);
               s_next.pend.gear_num = clamp16(wdat[15:0], apc_pkg::GEAR_MIN, 16'hFFFF);
            end

            apc_pkg::ADR_GEAR_DEN: begin
               wdat = merge({16'h0, s_reg.pend.gear_den}, WB_DAT_I, WB_SEL_I);
               s_next.pend.gear_den = clamp16(wdat[15:0], apc_pkg::GEAR_MIN, 16'hFFFF);
            end

            // load pulses per revolution, power-on set
            apc_pkg::ADR_REV_PUL_LO: begin
               s_next.pend.rev_lo = merge(s_reg.pend.rev_lo, WB_DAT_I, WB_SEL_I);
            end

            apc_pkg::ADR_REV_PUL_HI: begin
               wdat = merge({25'h0, s_reg.pend.rev_hi}, WB_DAT_I, WB_SEL_I);
               // values above the top limit saturate rather than wrap
               if (wdat > 32'(apc_pkg::REV_HI_MAX)) begin
                  s_next.pend.rev_hi = apc_pkg::REV_HI_MAX;
               end else begin
                  s_next.pend.rev_hi = wdat[6:0];
               end
            end

            // homing parameters act at once
            apc_pkg::ADR_HS_SPEED: begin
               wdat = merge({16'h0, s_reg.hs_speed}, WB_DAT_I, WB_SEL_I);
               s_next.hs_speed = clamp16(wdat[15:0], 16'h0000, apc_pkg::HS_SPEED_MAX);
            end

            apc_pkg::ADR_HS_TORQUE: begin
               wdat = merge({16'h0, s_reg.hs_torque}, WB_DAT_I, WB_SEL_I);
               s_next.hs_torque = clamp16(wdat[15:0], 16'h0000, apc_pkg::HS_TORQUE_MAX);
            end

            // done timing words, clamped into range
            apc_pkg::ADR_DWELL: begin
               wdat = merge({16'h0, s_reg.dwell}, WB_DAT_I, WB_SEL_I);
               s_next.dwell = clamp16(wdat[15:0], apc_pkg::TIME_MIN, apc_pkg::TIME_MAX);
            end

            apc_pkg::ADR_HOLD: begin
               wdat = merge({16'h0, s_reg.hold}, WB_DAT_I, WB_SEL_I);
               s_next.hold = clamp16(wdat[15:0], apc_pkg::TIME_MIN, apc_pkg::TIME_MAX);
            end

            // wide division count saturates at its top
            apc_pkg::ADR_DIV_WIDE: begin
               wdat = merge(s_reg.pend.div_wide, WB_DAT_I, WB_SEL_I);
               if (wdat > apc_pkg::DIV_MAX) begin
                  s_next.pend.div_wide = apc_pkg::DIV_MAX;
               end else begin
                  s_next.pend.div_wide = wdat;
               end
            end

            // mode and polarity wait for power-up
            apc_pkg::ADR_CTRL: begin
               wdat = merge({27'h0, s_reg.pend.pol, s_reg.cond, s_reg.pend.abs_mode}, WB_DAT_I, WB_SEL_I);
               s_next.pend.abs_mode = wdat[apc_pkg::CTRL_MODE_LSB +: 2];
               s_next.cond          = wdat[apc_pkg::CTRL_COND_LSB +: 2];
               s_next.pend.pol      = wdat[apc_pkg::CTRL_POL_BIT];
            end

            // legacy count acts at once
            apc_pkg::ADR_LEGACY_DIV: begin
               s_next.legacy_div = merge(s_reg.legacy_div, WB_DAT_I, WB_SEL_I);
            end

            // narrow word: byte lanes ignored
            apc_pkg::ADR_IRQ_MASK: begin
               s_next.irq_mask = WB_DAT_I[apc_pkg::IRQ_W-1:0];
            end

            default: begin
            end
         endcase
      end

      // read mux; unmapped addresses read zero and still ack
      if (rd_cyc) begin
         case (WB_ADR_I)
            // the pending set reads back, not the active one
            apc_pkg::ADR_LIN_OFS_LO: s_next.rdata = s_reg.pend.ofs_lo;
            apc_pkg::ADR_LIN_OFS_HI: s_next.rdata = s_reg.pend.ofs_hi;
            apc_pkg::ADR_GEAR_NUM:   s_next.rdata = {16'h0, s_reg.pend.gear_num};
            apc_pkg::ADR_GEAR_DEN:   s_next.rdata = {16'h0, s_reg.pend.gear_den};
            apc_pkg::ADR_REV_PUL_LO: s_next.rdata = s_reg.pend.rev_lo;
            apc_pkg::ADR_REV_PUL_HI: s_next.rdata = {25'h0, s_reg.pend.rev_hi};
            apc_pkg::ADR_HS_SPEED:   s_next.rdata = {16'h0, s_reg.hs_speed};
            apc_pkg::ADR_HS_TORQUE:  s_next.rdata = {16'h0, s_reg.hs_torque};
            apc_pkg::ADR_DWELL:      s_next.rdata = {16'h0, s_reg.dwell};
            apc_pkg::ADR_HOLD:       s_next.rdata = {16'h0, s_reg.hold};
            apc_pkg::ADR_DIV_WIDE:   s_next.rdata = s_reg.pend.div_wide;
            apc_pkg::ADR_CTRL:       s_next.rdata = {27'h0, s_reg.pend.pol, s_reg.cond, s_reg.pend.abs_mode};
            apc_pkg::ADR_LEGACY_DIV: s_next.rdata = s_reg.legacy_div;
            // status and event words
            apc_pkg::ADR_STATUS:     s_next.rdata = {29'h0, s_reg.booted, s_reg.hit, s_reg.done};
            apc_pkg::ADR_IRQ_STAT:   s_next.rdata = {29'h0, s_reg.irq_stat};
            apc_pkg::ADR_IRQ_MASK:   s_next.rdata = {29'h0, s_reg.irq_mask};
            // active offset, read only
            apc_pkg::ADR_ACT_OFS_LO: s_next.rdata = s_reg.act.ofs_lo;
            apc_pkg::ADR_ACT_OFS_HI: s_next.rdata = s_reg.act.ofs_hi;
            default:                 s_next.rdata = 32'h0;
         endcase
      end

      // power-on parameters copied to the active set only on power-up
      // a level held high keeps copying, so writes then act at once
      if (POWER_UP) begin
         s_next.act    = s_reg.pend;
         s_next.booted = 1'b1;
      end

      // millisecond prescaler, free running
      // a timer's first tick may come early: up to 1 ms of jitter
      if (s_reg.ms_pre == apc_pkg::CYC_PER_MS_M1) begin
         s_next.ms_pre = 15'h0;
         tick = 1'b1;
      end else begin
         s_next.ms_pre = s_reg.ms_pre + 15'h1;
      end

      // positioning done: dwell qualification, then optional hold
      if (!s_reg.done) begin
         // leaving the band restarts qualification
         if (!DEV_IN_BAND) begin
            s_next.dwell_cnt = 16'h0;
         end else if (tick) begin
            if (s_reg.dwell_cnt >= s_reg.dwell) begin
               // strictly longer than the dwell: one extra tick past the setting
               s_next.done     = 1'b1;
               s_next.hold_cnt = 16'h0;
               done_rise       = 1'b1;
            end else begin
               s_next.dwell_cnt = s_reg.dwell_cnt + 16'h1;
            end
         end
      end else begin
         // hold condition: a nonzero reference ends it at once
         if (s_reg.cond == apc_pkg::COND_HOLD) begin
            if (POS_REF_NONZERO) begin
               s_next.done = 1'b0;
               done_drop   = 1'b1;
            end else if (tick) begin
               s_next.hold_cnt = s_reg.hold_cnt + 16'h1;
               if (s_reg.hold_cnt + 16'h1 >= s_reg.hold) begin
                  s_next.done = 1'b0;
                  done_drop   = 1'b1;
               end
            end
         end else if (!DEV_IN_BAND) begin
            s_next.done = 1'b0;
            done_drop   = 1'b1;
         end
         // a fresh dwell is needed before done rises again
         if (done_drop) begin
            s_next.dwell_cnt = 16'h0;
         end
      end

      // hit-and-stop end detection and torque clamp
      // strict compare: speed equal to the threshold is no end
      s_next.hit = HIT_STOP_ACTIVE && (MOTOR_SPEED_RPM < s_reg.hs_speed);
      hit_rise   = s_next.hit && !s_reg.hit;
      // outside homing the full range is released
      if (HIT_STOP_ACTIVE) begin
         s_next.trq_lim = s_reg.hs_torque;
      end else begin
         s_next.trq_lim = apc_pkg::HS_TORQUE_MAX;
      end

      // division count choice; wide value wins from 35 up
      // legacy word acts at once, wide one after power-up
      if (s_reg.act.div_wide < apc_pkg::DIV_WIDE_MIN) begin
         s_next.div_used = s_reg.legacy_div;
      end else begin
         s_next.div_used = s_reg.act.div_wide;
      end

      // done pin level follows polarity
      s_next.done_pin = s_next.done ^ s_reg.act.pol;

      // sticky events: set wins over write-one-to-clear
      // clear first, then set, so an event in the clear cycle stays
      if (wr && WB_ADR_I == apc_pkg::ADR_IRQ_STAT) begin
         s_next.irq_stat = s_reg.irq_stat & ~WB_DAT_I[apc_pkg::IRQ_W-1:0];
      end
      if (done_rise) begin
         s_next.irq_stat[apc_pkg::IRQ_DONE_RISE] = 1'b1;
      end
      if (done_drop) begin
         s_next.irq_stat[apc_pkg::IRQ_DONE_DROP] = 1'b1;
      end
      if (hit_rise) begin
         s_next.irq_stat[apc_pkg::IRQ_HIT_STOP] = 1'b1;
      end
   end

   // state register with reset defaults and clock enable
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         s_reg <= '0;
         // power-on sets start at their defaults
         s_reg.pend.abs_mode <= apc_pkg::RST_ABS_MODE;
         s_reg.pend.pol      <= apc_pkg::RST_POL;
         s_reg.pend.gear_num <= apc_pkg::RST_GEAR_NUM;
         s_reg.pend.gear_den <= apc_pkg::RST_GEAR_DEN;
         s_reg.act.abs_mode  <= apc_pkg::RST_ABS_MODE;
         s_reg.act.pol       <= apc_pkg::RST_POL;
         s_reg.act.gear_num  <= apc_pkg::RST_GEAR_NUM;
         s_reg.act.gear_den  <= apc_pkg::RST_GEAR_DEN;
         // immediate parameters
         s_reg.cond          <= apc_pkg::RST_COND;
         s_reg.hs_speed      <= apc_pkg::RST_HS_SPEED;
         s_reg.hs_torque     <= apc_pkg::RST_HS_TORQUE;
         s_reg.dwell         <= apc_pkg::RST_DWELL;
         s_reg.hold          <= apc_pkg::RST_HOLD;
         // done inactive at default polarity, torque released
         s_reg.done_pin      <= apc_pkg::RST_POL;
         s_reg.trq_lim       <= apc_pkg::HS_TORQUE_MAX;
      end else if (CLK_EN) begin
         s_reg <= s_next;
      end
   end

   // outputs; linear offset only meaningful in linear mode
   assign WB_DAT_O        = s_reg.rdata;
   assign WB_ACK_O        = s_reg.ack;
   assign POS_DONE_OUT    = s_reg.done_pin;
   assign HIT_END_REACHED = s_reg.hit;
   assign TORQUE_LIMIT    = s_reg.trq_lim;
   assign DIVISION_COUNT  = s_reg.div_used;
   assign ABS_MODE        = s_reg.act.abs_mode;
   // offset and pulse words read zero outside their own mode
   assign POS_OFFSET      = (s_reg.act.abs_mode == apc_pkg::ABS_LINEAR)
                            ? {s_reg.act.ofs_hi, s_reg.act.ofs_lo}
                            : 64'h0;
   // active gear terms for rotating mode
   assign GEAR_NUM        = s_reg.act.gear_num;
   assign GEAR_DEN        = s_reg.act.gear_den;
   assign REV_PULSES      = (s_reg.act.abs_mode == apc_pkg::ABS_ROTATING)
                            ? {s_reg.act.rev_hi, s_reg.act.rev_lo}
                            : 39'h0;
   // unregistered level, so it follows a clear at once
   assign IRQ             = |(s_reg.irq_stat & s_reg.irq_mask);

endmodule // apc_top

`default_nettype wire

// [sim/apc_top_sva.sv]
// assertion checker for the position parameter block ports
`timescale 1ns/10ps
`default_nettype none
module apc_top_sva (
   input wire logic        CORE_CLK,
   input wire logic        SYS_RST,
   input wire logic        CLK_EN,
   input wire logic        POWER_UP,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_ACK_O,
   input wire logic        HIT_STOP_ACTIVE,
   input wire logic        HIT_END_REACHED,
   input wire logic [15:0] TORQUE_LIMIT,
   input wire logic [1:0]  ABS_MODE,
   input wire logic [63:0] POS_OFFSET,
   input wire logic [15:0] GEAR_NUM,
   input wire logic [15:0] GEAR_DEN,
   input wire logic [38:0] REV_PULSES
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // a request the slave takes at this edge
   sequence req_taken;
      CLK_EN && WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   // idle bus seen while the block is running
   sequence bus_idle;
      CLK_EN && !(WB_CYC_I && WB_STB_I);
   endsequence

   // bus handshake
   ack_answer_a: assert property (req_taken |=> WB_ACK_O)
      else $error("request not acknowledged one cycle later");
   ack_single_a: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
      else $error("acknowledge longer than one cycle");
   ack_idle_a: assert property (bus_idle |=> !WB_ACK_O)
      else $error("acknowledge without request");

   // hit-and-stop outputs follow the homing state
   torque_idle_a: assert property (CLK_EN && !HIT_STOP_ACTIVE |=> TORQUE_LIMIT == 16'h0BB8)
      else $error("torque limit not released outside homing");
   torque_cap_a: assert property (TORQUE_LIMIT <= apc_pkg::HS_TORQUE_MAX)
      else $error("torque limit above range");
   hit_idle_a: assert property (CLK_EN && !HIT_STOP_ACTIVE |=> !HIT_END_REACHED)
      else $error("end reached flagged outside homing");

   // power-on set is in range, mode gated, and moves only at power-up
   gear_range_a: assert property (GEAR_NUM != 16'h0000 && GEAR_DEN != 16'h0000)
      else $error("gear ratio term is zero");
   offset_mode_a: assert property (ABS_MODE != apc_pkg::ABS_LINEAR |-> POS_OFFSET == 64'h0)
      else $error("offset shown outside linear mode");
   rev_mode_a: assert property (ABS_MODE != apc_pkg::ABS_ROTATING |-> REV_PULSES == 39'h0)
      else $error("load pulses shown outside rotating mode");
   param_hold_a: assert property (!POWER_UP |=> $stable(POS_OFFSET) && $stable(GEAR_NUM)
      && $stable(GEAR_DEN) && $stable(ABS_MODE) && $stable(REV_PULSES))
      else $error("power-on parameter changed without power-up");
endmodule // apc_top_sva

bind apc_top apc_top_sva u_sva (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
   .POWER_UP(POWER_UP), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
   .HIT_STOP_ACTIVE(HIT_STOP_ACTIVE), .HIT_END_REACHED(HIT_END_REACHED), .TORQUE_LIMIT(TORQUE_LIMIT),
   .ABS_MODE(ABS_MODE), .POS_OFFSET(POS_OFFSET), .GEAR_NUM(GEAR_NUM), .GEAR_DEN(GEAR_DEN),
   .REV_PULSES(REV_PULSES));
`default_nettype wire

// [sim/apc_host_model.sv]
// host-side motion model feeding deviation, reference and speed lines
`timescale 1ns/10ps
`default_nettype none
module apc_host_model (
   input  wire logic        clk,
   input  wire logic        band_cmd,
   input  wire logic        ref_cmd,
   input  wire logic        hit_cmd,
   input  wire logic [15:0] spd_cmd,
   output logic             dev_in_band,
   output logic             pos_ref_nonzero,
   output logic             hit_active,
   output logic      [15:0] speed
);
   // lines follow the commands one edge late, like a sampled motion loop
   initial begin
      dev_in_band = 1'h0;
      pos_ref_nonzero = 1'h0;
      hit_active = 1'h0;
      speed = 16'h0;
   end
   always @(posedge clk) begin
      dev_in_band     <= band_cmd;
      pos_ref_nonzero <= ref_cmd;
      hit_active      <= hit_cmd;
      speed           <= spd_cmd;
   end
endmodule // apc_host_model
`default_nettype wire

// [sim/apc_top_tb.sv]
// self-checking bench for the position parameter block
`timescale 1ns/10ps
`default_nettype none
module apc_top_tb;
   typedef struct {logic [7:0] a; logic [31:0] r, w, e;} apc_row_t;
   logic        CORE_CLK = 1'h0, SYS_RST = 1'h1, POWER_UP = 1'h0, en = 1'h1;
   logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, band = 1'h0, rf = 1'h0, hit = 1'h0;
   logic [15:0] spd = 16'h0, tlim, gnum, gden, mspd;
   logic [7:0]  adr = 8'h0;
   logic [31:0] dat = 32'h0, rdat, lo, hi, dcnt;
   logic        ack, done, hend, irq, dev, pref, hsa;
   logic [1:0]  amode;
   logic [63:0] pofs;
   logic [38:0] rev;
   logic [31:0] q[$];
   int          failures = 0, cmp_count = 0;
   // address, reset value, written value, value read back after clamping
   apc_row_t    tbl[11] = '{'{8'h08, 32'hFFFF, 32'h0, 32'h1}, '{8'h0C, 32'h1, 32'h7, 32'h7},
      '{8'h14, 32'h0, 32'hC8, 32'h7F}, '{8'h18, 32'h2, 32'h7D0, 32'h3E8}, '{8'h1C, 32'h3E8, 32'hFA0, 32'hBB8},
      '{8'h20, 32'h0, 32'h0, 32'h1}, '{8'h24, 32'h1, 32'h9C40, 32'h7530}, '{8'h28, 32'h0, 32'h40000, 32'h3FFFF},
      '{8'h30, 32'h0, 32'h1234, 32'h1234}, '{8'h34, 32'h0, 32'hFFFFFFFF, 32'h0},
      '{8'h50, 32'h0, 32'hFFFFFFFF, 32'h0}};

   // 25 MHz core clock
   always #20 CORE_CLK = ~CORE_CLK;

   apc_top dut (
      .CORE_CLK(CORE_CLK),
      .SYS_RST(SYS_RST),
      .CLK_EN(en),
      .POWER_UP(POWER_UP),
      .WB_CYC_I(cyc),
      .WB_STB_I(stb),
      .WB_WE_I(we),
      .WB_ADR_I(adr),
      .WB_SEL_I(4'hF),
      .WB_DAT_I(dat),
      .WB_DAT_O(rdat),
      .WB_ACK_O(ack),
      .HIT_STOP_ACTIVE(hsa),
      .MOTOR_SPEED_RPM(mspd),
      .DEV_IN_BAND(dev),
      .POS_REF_NONZERO(pref),
      .POS_DONE_OUT(done),
      .HIT_END_REACHED(hend),
      .TORQUE_LIMIT(tlim),
      .DIVISION_COUNT(dcnt),
      .ABS_MODE(amode),
      .POS_OFFSET(pofs),
      .GEAR_NUM(gnum),
      .GEAR_DEN(gden),
      .REV_PULSES(rev),
      .IRQ(irq)
   );

   apc_host_model host (
      .clk(CORE_CLK),
      .band_cmd(band),
      .ref_cmd(rf),
      .hit_cmd(hit),
      .spd_cmd(spd),
      .dev_in_band(dev),
      .pos_ref_nonzero(pref),
      .hit_active(hsa),
      .speed(mspd)
   );

   task automatic check(input logic [63:0] s, input logic [63:0] e, input string n);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic close_out();
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one classic cycle, held until ack is sampled, bounded wait
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge CORE_CLK);
         n++;
      end while (ack !== 1'h1 && n < 20);
      cyc <= 1'h0;
      stb <= 1'h0;
      if (ack !== 1'h1) begin
         failures++;
         close_out();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'h0, a, 32'h0);
   endtask

   task automatic clks(input int n);
      repeat (n) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask

   task automatic pwr();
      @(posedge CORE_CLK);
      POWER_UP <= 1'h1;
      @(posedge CORE_CLK);
      POWER_UP <= 1'h0;
      clks(2);
   endtask

   // read answers are matched against the oldest noted value
   always @(posedge CORE_CLK) begin
      if (ack === 1'h1 && we === 1'h0 && q.size() > 0) begin
         check(rdat, q.pop_front(), "read data");
      end
   end

   initial begin
      int n;
      void'($urandom(16));
      repeat (8) @(posedge CORE_CLK);
      SYS_RST <= 1'h0;
      clks(1);
      check(done, 64'h1, "done pin idle");
      foreach (tbl[i]) begin
         rd(tbl[i].a, tbl[i].r);
         bus(1'h1, tbl[i].a, tbl[i].w);
         rd(tbl[i].a, tbl[i].e);
      end
      // pending offset stays invisible until power-up
      lo = $urandom();
      hi = $urandom();
      bus(1'h1, 8'h00, lo);
      bus(1'h1, 8'h04, hi);
      bus(1'h1, 8'h2C, 32'h0000000D);
      rd(8'h04, hi);
      clks(1);
      check({gnum, pofs[15:0]}, 64'hFFFF0000, "set before power-up");
      pwr();
      check(pofs, {hi, lo}, "offset");
      check({gnum, gden, 14'h0, amode}, 64'h0000000100070001, "gear and mode");
      check(dcnt, 64'h3FFFF, "division");
      for (int v = 34; v < 36; v++) begin
         lo = $urandom();
         bus(1'h1, 8'h10, lo);
         bus(1'h1, 8'h28, 32'(v));
         bus(1'h1, 8'h2C, 32'h0000000E);
         pwr();
         check(dcnt, (v < 35) ? 64'h1234 : 64'(v), "division");
         check({pofs[24:0], rev}, {25'h0, 7'h7F, lo}, "load pulses");
      end
      // hit-and-stop: clamp, end judgement at the threshold boundary, irq
      bus(1'h1, 8'h1C, 32'h1F4);
      bus(1'h1, 8'h3C, 32'h4);
      hit <= 1'h1;
      spd <= 16'h1;
      en  <= 1'h0;
      clks(3);
      check({tlim, hend}, {16'hBB8, 1'h0}, "frozen by enable");
      @(posedge CORE_CLK);
      en  <= 1'h1;
      clks(3);
      check({tlim, 7'h0, hend, 7'h0, irq}, 64'h01F40101, "hit stop");
      @(posedge CORE_CLK);
      spd <= 16'h3E8;
      clks(3);
      check(hend, 64'h0, "hit end at threshold");
      bus(1'h1, 8'h38, 32'h7);
      clks(1);
      check(irq, 64'h0, "irq cleared");
      // dwell of 1 ms must pass in full before the done pin turns active high
      @(posedge CORE_CLK);
      hit <= 1'h0;
      band <= 1'h1;
      n = 0;
      while (done !== 1'h1 && n < 90000) begin
         @(posedge CORE_CLK);
         n++;
      end
      check(n > 25000 && n < 90000, 64'h1, "dwell");
      if (done !== 1'h1) begin
         close_out();
      end
      rf <= 1'h1;
      clks(3);
      check(done, 64'h0, "done on reference");
      rd(8'h38, 32'h3);
      check(irq, 64'h0, "irq masked");
      bus(1'h1, 8'h3C, 32'h1);
      clks(1);
      check(irq, 64'h1, "irq unmasked");
      bus(1'h1, 8'h38, 32'h3);
      clks(1);
      check({irq, 31'h0, q.size()}, 64'h0, "irq and reads");
      close_out();
   end
endmodule // apc_top_tb
`default_nettype wire
